// ### hdl/fuch_defs.vh
// Purpose: constants for the flash update command handler
// Assumes: byte-wide serial port and flash sequencer outside this block
// Notes:   widths of every macro match the signals that use them
//
// Overview of operation
// - hold one 256-byte page before programming
// - erase and program only blocks after boot block
// - poll enable indication, then send request reply
// - byte 0x50 erases all blocks after boot block, then programs
// - byte 0x52 reads requested bytes back
// - replies 0x00 normal, 0x01 error, 0x11 request
// - erase or program failure: error reply, halt
// - erase every block after boot block before the first request reply
// - take 8 parameter bytes, request again, program
// - bad program address: error reply, halt
// - accept read-space program addresses, convert internally
// - program/erase address is read address plus base
// - one request per 256-byte chunk from host
// - program per chunk, pad short tail with 0xff
// - normal reply once requested size is programmed
// - read command: request reply, then 8 parameter bytes
// - read bytes in order and transmit them
// - bad read address: skip read, error, halt
// - link is 8 data bits, no parity, one stop
`ifndef FUCH_DEFS_VH
`define FUCH_DEFS_VH

`define FUCH_CMD_PROG      8'h50
`define FUCH_CMD_READ      8'h52
`define FUCH_RPL_OK        8'h00
`define FUCH_RPL_ERR       8'h01
`define FUCH_RPL_REQ       8'h11
`define FUCH_PAD_BYTE      8'hff
`define FUCH_PAGE_BYTES    9'h100
`define FUCH_PAGE_STEP     32'h0000_0100
`define FUCH_PE_BASE       32'h8080_0000
`define FUCH_PROG_LO       32'h0000_2000
`define FUCH_ARRAY_HI      32'h0007_ffff
`define FUCH_BLK_FIRST     4'h1
`define FUCH_BLK_LAST      4'he
`define FUCH_BLK_SMALL_CNT 4'h8
`define FUCH_BLK_BIG_SKIP  4'h7
`define FUCH_PARAM_LAST    3'h7
`define FUCH_CHUNK_LAST    8'hff

`endif

// ### hdl/fuch_top.v
// Purpose: byte command interpreter between host serial port and flash sequencer
// Assumes: serial port delivers whole bytes; sequencer handshakes by req/done
// Notes:   one buffer page; after an erase, program or address failure the block halts until reset
`timescale 1ns/10ps
`include "fuch_defs.vh"

module fuch_top (
	input  wire        mclk_in,
	input  wire        rst_n_in,
	input  wire        program_erase_enable_pin_in,
	input  wire [7:0]  rx_data_in,
	input  wire        rx_valid_in,
	output reg  [7:0]  tx_data_out,
	output reg         tx_valid_out,
	input  wire        tx_ready_in,
	output reg         fls_erase_req_out,
	output reg         fls_prog_req_out,
	output reg         fls_read_req_out,
	output reg  [31:0] fls_addr_out,
	input  wire        fls_done_in,
	input  wire        fls_error_in,
	input  wire [7:0]  fls_rdata_in,
	input  wire [7:0]  fls_buf_idx_in,
	output reg  [7:0]  fls_buf_data_out,
	output reg         halted_out
);

	localparam [10:0] S_POLL  = 11'h001;
	localparam [10:0] S_SEND  = 11'h002;
	localparam [10:0] S_CMD   = 11'h004;
	localparam [10:0] S_ERASE = 11'h008;
	localparam [10:0] S_PARAM = 11'h010;
	localparam [10:0] S_CHK   = 11'h020;
	localparam [10:0] S_PDEC  = 11'h040;
	localparam [10:0] S_CHUNK = 11'h080;
	localparam [10:0] S_PROG  = 11'h100;
	localparam [10:0] S_READ  = 11'h200;
	localparam [10:0] S_HALT  = 11'h400;

	reg  [10:0] st_r;
	reg  [10:0] ret_r;
	reg         pe_s1_r;
	reg         pe_s2_r;
	reg         pe_s3_r;
	reg         pe_ok_r;
	reg         wr_mode_r;
	reg  [3:0]  blk_r;
	reg  [2:0]  pcnt_r;
	reg  [63:0] param_r;
	reg  [31:0] addr_r;
	reg  [31:0] rem_r;
	reg  [7:0]  cnt_r;
	reg  [7:0]  buf_mem [0:255];

	wire [8:0]  chunk_len;
	wire [31:0] rem_after;
	wire        buf_we;
	wire [7:0]  buf_wd;

	// program/erase address of an erase block; small blocks first, then big
	function [31:0] blk_addr;
		input [3:0] b;
		begin
			if (b < `FUCH_BLK_SMALL_CNT) begin
				blk_addr = `FUCH_PE_BASE + {15'h0, b, 13'h0};
			end else begin
				blk_addr = `FUCH_PE_BASE + {12'h0, b - `FUCH_BLK_BIG_SKIP, 16'h0};
			end
		end
	endfunction

	assign chunk_len = (rem_r >= {23'h0, `FUCH_PAGE_BYTES}) ? `FUCH_PAGE_BYTES : rem_r[8:0];
	assign rem_after = rem_r - {23'h0, chunk_len};
	assign buf_we    = st_r[7] & rx_valid_in;
	// bytes past the valid tail are still taken from the host but stored as pad
	assign buf_wd    = ({1'b0, cnt_r} < chunk_len) ? rx_data_in : `FUCH_PAD_BYTE;

	// page buffer, no reset: contents are always rewritten before use
	always @(posedge mclk_in) begin
		if (buf_we) begin
			buf_mem[cnt_r] <= buf_wd;
		end
	end

	// enable pin: three stages, level accepted when last two agree
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pe_s1_r <= 1'b0;
			pe_s2_r <= 1'b0;
			pe_s3_r <= 1'b0;
			pe_ok_r <= 1'b0;
		end else begin
			pe_s1_r <= program_erase_enable_pin_in;
			pe_s2_r <= pe_s1_r;
			pe_s3_r <= pe_s2_r;
			if (pe_s2_r == pe_s3_r) begin
				pe_ok_r <= pe_s3_r;
			end
		end
	end

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fls_buf_data_out <= 8'h00;
		end else begin
			fls_buf_data_out <= buf_mem[fls_buf_idx_in];
		end
	end

	task go_send;
		input [7:0]  b;
		input [10:0] nxt;
		begin
			tx_data_out  <= b;
			tx_valid_out <= 1'b1;
			ret_r        <= nxt;
			st_r         <= S_SEND;
		end
	endtask

	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r              <= S_POLL;
			ret_r             <= S_POLL;
			tx_data_out       <= 8'h00;
			tx_valid_out      <= 1'b0;
			fls_erase_req_out <= 1'b0;
			fls_prog_req_out  <= 1'b0;
			fls_read_req_out  <= 1'b0;
			fls_addr_out      <= 32'h0000_0000;
			halted_out        <= 1'b0;
			wr_mode_r         <= 1'b0;
			blk_r             <= 4'h0;
			pcnt_r            <= 3'h0;
			param_r           <= 64'h0;
			addr_r            <= 32'h0000_0000;
			rem_r             <= 32'h0000_0000;
			cnt_r             <= 8'h00;
		end else begin
			case (st_r)
			S_POLL: begin
				if (pe_ok_r) begin
					go_send(`FUCH_RPL_REQ, S_CMD);
				end
			end
			S_SEND: begin
				if (tx_ready_in) begin
					tx_valid_out <= 1'b0;
					st_r         <= ret_r;
					if (ret_r == S_HALT) begin
						halted_out <= 1'b1;
					end
				end
			end
			S_CMD: begin
				if (rx_valid_in) begin
					pcnt_r <= 3'h0;
					if (rx_data_in == `FUCH_CMD_PROG) begin
						wr_mode_r         <= 1'b1;
						blk_r             <= `FUCH_BLK_FIRST;
						fls_addr_out      <= blk_addr(`FUCH_BLK_FIRST);
						fls_erase_req_out <= 1'b1;
						st_r              <= S_ERASE;
					end else if (rx_data_in == `FUCH_CMD_READ) begin
						wr_mode_r <= 1'b0;
						go_send(`FUCH_RPL_REQ, S_PARAM);
					end
					// any other byte is dropped and the wait goes on
				end
			end
			S_ERASE: begin
				if (fls_done_in) begin
					fls_erase_req_out <= 1'b0;
					if (fls_error_in) begin
						go_send(`FUCH_RPL_ERR, S_HALT);
					end else if (blk_r == `FUCH_BLK_LAST) begin
						go_send(`FUCH_RPL_REQ, S_PARAM);
					end else begin
						blk_r             <= blk_r + 4'h1;
						fls_addr_out      <= blk_addr(blk_r + 4'h1);
						fls_erase_req_out <= 1'b1;
					end
				end
			end
			S_PARAM: begin
				if (rx_valid_in) begin
					param_r <= {param_r[55:0], rx_data_in};
					pcnt_r  <= pcnt_r + 3'h1;
					if (pcnt_r == `FUCH_PARAM_LAST) begin
						st_r <= S_CHK;
					end
				end
			end
			S_CHK: begin
				addr_r <= param_r[63:32];
				rem_r  <= param_r[31:0];
				if (wr_mode_r) begin
					if (param_r[63:32] < `FUCH_PROG_LO || param_r[63:32] > `FUCH_ARRAY_HI) begin
						go_send(`FUCH_RPL_ERR, S_HALT);
					end else begin
						st_r <= S_PDEC;
					end
				end else begin
					if (param_r[63:32] > `FUCH_ARRAY_HI) begin
						go_send(`FUCH_RPL_ERR, S_HALT);
					end else begin
						st_r <= S_READ;
					end
				end
			end
			S_PDEC: begin
				cnt_r <= 8'h00;
				if (rem_r == 32'h0000_0000) begin
					go_send(`FUCH_RPL_OK, S_POLL);
				end else begin
					go_send(`FUCH_RPL_REQ, S_CHUNK);
				end
			end
			S_CHUNK: begin
				if (rx_valid_in) begin
					cnt_r <= cnt_r + 8'h01;
					if (cnt_r == `FUCH_CHUNK_LAST) begin
						fls_addr_out     <= addr_r + `FUCH_PE_BASE;
						fls_prog_req_out <= 1'b1;
						st_r             <= S_PROG;
					end
				end
			end
			S_PROG: begin
				if (fls_done_in) begin
					fls_prog_req_out <= 1'b0;
					if (fls_error_in) begin
						go_send(`FUCH_RPL_ERR, S_HALT);
					end else begin
						rem_r  <= rem_after;
						addr_r <= addr_r + `FUCH_PAGE_STEP;
						st_r   <= S_PDEC;
					end
				end
			end
			S_READ: begin
				if (fls_read_req_out) begin
					if (fls_done_in) begin
						fls_read_req_out <= 1'b0;
						rem_r            <= rem_r - 32'h0000_0001;
						addr_r           <= addr_r + 32'h0000_0001;
						go_send(fls_rdata_in, S_READ);
					end
				end else if (rem_r == 32'h0000_0000) begin
					st_r <= S_POLL;
				end else begin
					fls_addr_out     <= addr_r;
					fls_read_req_out <= 1'b1;
				end
			end
			S_HALT: begin
				halted_out <= 1'b1;
			end
			default: begin
				st_r <= S_HALT;
			end
			endcase
		end
	end

endmodule

// ### verif/fuch_monitor.sv
// Purpose: port checker for the command handler
// Assumes: one clock, async active-low reset
// Notes: read data shares the tx port, so only the 0x01 error reply before halt is checked
`timescale 1ns/10ps
module fuch_monitor (
	input wire mclk_in,
	input wire rst_n_in,
	input wire [7:0] tx_data_out,
	input wire tx_valid_out,
	input wire tx_ready_in,
	input wire fls_erase_req_out,
	input wire fls_prog_req_out,
	input wire fls_read_req_out,
	input wire [31:0] fls_addr_out,
	input wire halted_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	property p_hold; tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out); endproperty
	a_hold: assert property (p_hold) else $error("tx byte not held");
	property p_drop; tx_valid_out && tx_ready_in |=> !tx_valid_out; endproperty
	a_drop: assert property (p_drop) else $error("tx valid stuck");
	property p_ers; fls_erase_req_out |-> fls_addr_out inside {[32'h8080_2000:32'h8087_0000]}; endproperty
	a_ers: assert property (p_ers) else $error("erase outside blocks");
	property p_prg; fls_prog_req_out |-> fls_addr_out inside {[32'h8080_2000:32'h8087_ffff]}; endproperty
	a_prg: assert property (p_prg) else $error("program address bad");
	property p_rd; fls_read_req_out |-> fls_addr_out <= 32'h0007_ffff; endproperty
	a_rd: assert property (p_rd) else $error("read outside array");
	property p_one; $onehot0({fls_erase_req_out, fls_prog_req_out, fls_read_req_out}); endproperty
	a_one: assert property (p_one) else $error("two flash requests");
	property p_halt; $rose(halted_out) |-> $past(tx_valid_out && tx_data_out == 8'h01); endproperty
	a_halt: assert property (p_halt) else $error("halt without error reply");
	property p_stay; halted_out |=> halted_out && !tx_valid_out && !fls_prog_req_out; endproperty
	a_stay: assert property (p_stay) else $error("activity after halt");
endmodule
bind fuch_top fuch_monitor u_mon (.*);

// ### verif/fuch_host.sv
// Purpose: host computer end of the byte link
// Assumes: framing done by the serial port
// Notes: slow mode stalls ready every other cycle
`timescale 1ns/10ps
module fuch_host (
	input  wire       clk_in,
	input  wire       slow_in,
	input  wire [7:0] tx_data_in,
	input  wire       tx_valid_in,
	output reg        tx_ready_out = 1'b0,
	output reg  [7:0] rx_data_out = 8'h00,
	output reg        rx_valid_out = 1'b0
);
	logic [7:0] got[$];
	always @(posedge clk_in) begin
		tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
		if (tx_valid_in && tx_ready_out)
			got.push_back(tx_data_in);
	end
	task send(input logic [7:0] b);
		@(posedge clk_in);
		rx_data_out <= b;
		rx_valid_out <= 1'b1;
		@(posedge clk_in);
		rx_valid_out <= 1'b0;
		rx_data_out <= ~b; // no stale byte left on the line
	endtask
	task send32(input logic [31:0] w);
		for (int i = 3; i >= 0; i--)
			send(w[i*8 +: 8]);
	endtask
endmodule

// ### verif/tb_fuch_top.sv
// Purpose: self-checking bench for the command handler
// Assumes: flash sequencer answers in 4 cycles
// Notes: an error flag fails every later done
`timescale 1ns/10ps
module tb_fuch_top;
	logic clk = 0, rst_n = 0, pin = 0, done = 0, ferr = 0, slow = 0;
	logic [7:0] tx_data, rx_data, rdata = 0, bdat, bidx = 8'h01;
	logic tx_valid, tx_ready, rx_valid, ers, prg, rd, halted;
	logic [31:0] addr, ea[$];
	logic [39:0] pa[$];
	int mismatches = 0, check_count = 0, dly = 0;
	always #4 clk = ~clk;
	fuch_host host (.clk_in(clk), .slow_in(slow), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
		.tx_ready_out(tx_ready), .rx_data_out(rx_data), .rx_valid_out(rx_valid));
	fuch_top DUT (.mclk_in(clk), .rst_n_in(rst_n), .program_erase_enable_pin_in(pin),
		.rx_data_in(rx_data), .rx_valid_in(rx_valid), .tx_data_out(tx_data),
		.tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .fls_erase_req_out(ers),
		.fls_prog_req_out(prg), .fls_read_req_out(rd), .fls_addr_out(addr), .fls_done_in(done),
		.fls_error_in(ferr), .fls_rdata_in(rdata), .fls_buf_idx_in(bidx),
		.fls_buf_data_out(bdat), .halted_out(halted));
	always @(posedge clk) begin
		done <= 1'b0;
		rdata <= addr[7:0];
		if ((ers || prg || rd) && !done) dly <= dly + 1;
		if (dly == 3) begin
			done <= 1'b1;
			dly <= 0;
			if (ers) ea.push_back(addr);
			if (prg) pa.push_back({addr, bdat});
		end
	end
	task check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task reply(input logic [7:0] exp);
		int n;
		n = 0;
		while (host.got.size() == 0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		check("tx byte", host.got.size() ? host.got.pop_front() : 40'hx, exp);
	endtask
	task restart;
		rst_n <= 1'b0;
		pin <= 1'b0;
		ferr <= 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		host.got.delete();
		repeat (20) @(posedge clk);
		check("early tx", host.got.size(), 0);
		pin <= 1'b1;
		reply(8'h11);
	endtask
	task t_write;
		host.send(8'h50);
		reply(8'h11);
		check("erases", ea.size(), 14);
		for (int i = 0; i < 14; i++)
			check("erase addr", ea[i], i < 7 ? 32'h8080_2000 + i * 32'h2000
				: 32'h8081_0000 + (i - 7) * 32'h1_0000);
		host.send32(32'h0000_2000);
		host.send32(32'h0000_0101);
		reply(8'h11);
		for (int c = 0; c < 2; c++) begin
			bidx <= c ? 8'hc3 : 8'h7f;
			for (int i = 0; i < 256; i++)
				host.send(i[7:0]);
			reply(c ? 8'h00 : 8'h11);
		end
		check("pages", pa.size(), 2);
		check("page 0", pa[0], {32'h8080_2000, 8'h7f});
		check("page 1", pa[1], {32'h8080_2100, 8'hff});
	endtask
	task t_read;
		reply(8'h11);
		host.send(8'h33);
		host.send(8'h52);
		reply(8'h11);
		host.send32(32'h0007_fffe);
		host.send32(32'h0000_0002);
		reply(8'hfe);
		reply(8'hff);
		reply(8'h11);
	endtask
	task t_fail(input logic [7:0] cmd, input logic [31:0] a, input logic e);
		restart;
		ferr <= e;
		host.send(cmd);
		if (!e) begin
			reply(8'h11);
			host.send32(a);
			host.send32(32'h0000_0010);
		end
		reply(8'h01);
		host.send(8'h52);
		repeat (30) @(posedge clk);
		check("halted", halted, 1);
		check("silent", host.got.size(), 0);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		report_and_stop;
	end
	initial begin
		restart;
		slow <= 1'b1;
		t_write;
		slow <= 1'b0;
		t_read;
		t_fail(8'h50, 32'h0, 1'b1);
		t_fail(8'h50, 32'h0000_1fff, 1'b0);
		t_fail(8'h52, 32'h0008_0000, 1'b0);
		report_and_stop;
	end
endmodule
